// [core/adcsp_buf.sv]
`timescale 1ns/100ps
module adcsp_buf #(
  parameter int W = 22
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // fill side
  input wire logic IN_VALID_I,
  input wire logic [W-1:0] IN_DATA_I,
  output logic IN_READY_O,
  // drain side
  output logic OUT_VALID_O,
  output logic [W-1:0] OUT_DATA_O,
  input wire logic OUT_READY_I
);

  // ----------------------------------------------------------------
  // two-entry store
  // ----------------------------------------------------------------
  logic [W-1:0] mem_r [2];
  logic wr_r;
  logic rd_r;
  logic [1:0] cnt_r;
  wire push_w = IN_VALID_I & IN_READY_O;
  wire pop_w = OUT_VALID_O & OUT_READY_I;

  assign IN_READY_O = (cnt_r != 2'h2);
  assign OUT_VALID_O = (cnt_r != 2'h0);
  assign OUT_DATA_O = mem_r[rd_r];

  always_ff @(posedge CLK_I) begin
    if (push_w) begin
      mem_r[wr_r] <= IN_DATA_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      wr_r <= wr_r ^ push_w;
      rd_r <= rd_r ^ pop_w;
      cnt_r <= cnt_r + {1'b0, push_w} - {1'b0, pop_w};
    end
  end

endmodule : adcsp_buf

// [core/adcsp_pkg.sv]
package adcsp_pkg;

  // ----------------------------------------------------------------
  // word and pins
  // ----------------------------------------------------------------
  localparam int WORD_W = 22;
  localparam int LANES = 4;
  localparam int PIN_N = 4;
  localparam int PIN_SCLK = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_SDI = 2;
  localparam int PIN_TRIG = 3;
  // idle level of the pins: chip select high, the rest low
  localparam logic [3:0] PIN_RST = 4'h2;

  // ----------------------------------------------------------------
  // output protocol register fields
  // ----------------------------------------------------------------
  localparam int CLKSRC_HI = 7;
  localparam int CLKSRC_LO = 6;
  localparam int RATE_BIT = 4;
  localparam int LANE_HI = 3;
  localparam int LANE_LO = 2;
  localparam int FAMILY_HI = 1;
  localparam int FAMILY_LO = 0;
  localparam logic [1:0] FAMILY_SRC = 2'h3;
  localparam logic [7:0] PROTO_CHAIN0 = 8'h00;
  localparam logic [7:0] PROTO_CHAIN1 = 8'h01;
  localparam logic [7:0] PROTO_RST = 8'h00;
  localparam logic [1:0] LANE_DUAL = 2'h2;
  localparam logic [1:0] LANE_QUAD = 2'h3;
  localparam logic [1:0] CLK_EXT = 2'h0;
  localparam logic [1:0] CLK_INT = 2'h1;
  localparam logic [1:0] CLK_DIV2 = 2'h2;

  // ----------------------------------------------------------------
  // optimal frame lengths in output clocks, and oscillator dividers
  // ----------------------------------------------------------------
  localparam logic [3:0] FRAME_LONG = 4'hA;
  localparam logic [3:0] FRAME_MID = 4'h5;
  localparam logic [3:0] FRAME_SHORT = 4'h3;
  localparam logic [7:0] DIV_ONE = 8'h01;
  localparam logic [7:0] DIV_TWO = 8'h02;
  localparam logic [7:0] DIV_FOUR = 8'h04;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SPI = 4'b0010,
    ST_SRC = 4'b0100,
    ST_END = 4'b1000
  } adcsp_state_t;

endpackage : adcsp_pkg

// [core/adcsp_port.sv]
`timescale 1ns/100ps
// Functional notes
// - single rate: strobe rises, bits launch then
// - double rate: every strobe edge launches bits
// - all clock, lane, rate codes supported
// - frame lengths 10, 5 or 3 clocks
// - chaining merges output and input words
// - trigger rising edge samples the input
// - launch edge drives chain MSB out
// - capture edge shifts input into LSB when chaining
// - chip select rise decodes the chain
// - strobe pin carries the output clock
// - clock source codes: echo, osc, /2, /4
// - dual and quad launch on more lanes
module adcsp_port import adcsp_pkg::*; #(
  parameter int OSC_HALF = 1
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // serial pins
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic SDI_I,
  input wire logic CONV_TRIG_I,
  output logic READY_STROBE_OUT_O,
  output logic [3:0] SDO_O,
  output logic [3:0] SDO_OE_O,
  // configuration
  input wire logic [7:0] OUTPUT_PROTOCOL_REGISTER_I,
  input wire logic [1:0] INPUT_PROTOCOL_REGISTER_I,
  // converter side
  output logic SAMPLE_O,
  input wire logic RESULT_VALID_I,
  input wire logic [21:0] RESULT_DATA_I,
  output logic RESULT_READY_O,
  // decoded chain contents
  output logic CHAIN_VALID_O,
  output logic [21:0] CHAIN_WORD_O
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [2:0] lane_num(input logic [1:0] code);
    lane_num = (code == LANE_QUAD) ? 3'h4 : (code == LANE_DUAL) ? 3'h2 : 3'h1;
  endfunction : lane_num

  function automatic logic [3:0] frame_clks(input logic [1:0] code, input logic ddr);
    if (code == LANE_QUAD) begin
      frame_clks = ddr ? FRAME_SHORT : FRAME_MID;
    end else if (code == LANE_DUAL) begin
      frame_clks = ddr ? FRAME_MID : FRAME_LONG;
    end else begin
      frame_clks = FRAME_LONG;
    end
  endfunction : frame_clks

  // lane 0 carries the most significant bit of each slot
  function automatic logic [3:0] lanes_out(input logic [21:0] c, input logic [2:0] n);
    case (n)
      3'h4: lanes_out = {c[18], c[19], c[20], c[21]};
      3'h2: lanes_out = {2'h0, c[20], c[21]};
      default: lanes_out = {3'h0, c[21]};
    endcase
  endfunction : lanes_out

  function automatic logic [21:0] shl(input logic [21:0] c, input logic [2:0] n, input logic b);
    case (n)
      3'h4: shl = {c[17:0], 3'h0, b};
      3'h2: shl = {c[19:0], 1'b0, b};
      default: shl = {c[20:0], b};
    endcase
  endfunction : shl

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  logic [3:0] lvl_r;
  // a level moves only once the second and third stages agree
  wire [3:0] lvl_nxt = (s3_r & ~(s2_r ^ s3_r)) | (lvl_r & (s2_r ^ s3_r));
  wire [3:0] rise_w = lvl_nxt & ~lvl_r;
  wire [3:0] fall_w = ~lvl_nxt & lvl_r;

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      s1_r <= PIN_RST;
      s2_r <= PIN_RST;
      s3_r <= PIN_RST;
      lvl_r <= PIN_RST;
    end else begin
      s1_r <= {CONV_TRIG_I, SDI_I, CS_N_I, SCLK_I};
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  wire sclk_rise = rise_w[PIN_SCLK];
  wire sclk_fall = fall_w[PIN_SCLK];
  wire cs_fall = fall_w[PIN_CS];
  wire cs_rise = rise_w[PIN_CS];
  wire trig_rise = rise_w[PIN_TRIG];
  wire sdi_w = lvl_nxt[PIN_SDI];

  // ----------------------------------------------------------------
  // result buffer
  // ----------------------------------------------------------------
  logic buf_valid;
  logic [21:0] buf_data;
  logic state_idle;

  // words wait here until a frame opens; a slow host stalls the converter
  adcsp_buf #(
    .W(WORD_W)
  ) u_buf (
    .CLK_I(CLK_I),
    .NRST_I(NRST_I),
    .IN_VALID_I(RESULT_VALID_I),
    .IN_DATA_I(RESULT_DATA_I),
    .IN_READY_O(RESULT_READY_O),
    .OUT_VALID_O(buf_valid),
    .OUT_DATA_O(buf_data),
    .OUT_READY_I(cs_fall & state_idle)
  );

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  adcsp_state_t state_r;
  adcsp_state_t state_nxt;
  logic [7:0] cfg_r;
  logic [1:0] ipr_r;
  logic [21:0] chain_r;
  logic [3:0] sdo_r;
  logic rvs_r;
  logic [3:0] clocks_r;
  logic [7:0] div_cnt_r;
  logic sample_r;
  logic chain_valid_r;
  logic [21:0] chain_word_r;

  // fields are latched at frame start so a mid-frame write cannot tear it
  wire [7:0] cfg_w = state_idle ? OUTPUT_PROTOCOL_REGISTER_I : cfg_r;
  wire [1:0] ipr_w = state_idle ? INPUT_PROTOCOL_REGISTER_I : ipr_r;
  wire src_w = (cfg_w[FAMILY_HI:FAMILY_LO] == FAMILY_SRC);
  wire chain_w = (cfg_w == PROTO_CHAIN0) || (cfg_w == PROTO_CHAIN1);
  wire ddr_w = cfg_w[RATE_BIT];
  wire [1:0] clksel_w = cfg_w[CLKSRC_HI:CLKSRC_LO];
  wire [2:0] nl_w = lane_num(cfg_w[LANE_HI:LANE_LO]);
  wire [3:0] frame_w = frame_clks(cfg_w[LANE_HI:LANE_LO], ddr_w);
  wire [7:0] div_w = (clksel_w == CLK_INT) ? DIV_ONE :
                     (clksel_w == CLK_DIV2) ? DIV_TWO : DIV_FOUR;
  wire [7:0] div_lim_w = 8'(OSC_HALF) * div_w - 8'h01;
  wire cpha_w = ipr_w[0];
  wire cap_rising_w = (ipr_w[1] == ipr_w[0]);

  assign state_idle = (state_r == ST_IDLE);
  wire st_spi = (state_r == ST_SPI);
  wire st_src = (state_r == ST_SRC);

  // ----------------------------------------------------------------
  // edge selection
  // ----------------------------------------------------------------
  wire cap_w = st_spi & (cap_rising_w ? sclk_rise : sclk_fall);
  wire launch_spi_w = st_spi & (cap_rising_w ? sclk_fall : sclk_rise);
  wire div_en_w = (div_cnt_r == div_lim_w);
  wire tick_w = st_src & ((clksel_w == CLK_EXT) ? (sclk_rise | sclk_fall) : div_en_w);
  wire launch_src_w = tick_w & (!rvs_r | ddr_w);
  wire last_w = tick_w & rvs_r & (clocks_r + 4'h1 == frame_w);
  wire [21:0] load_w = buf_valid ? buf_data : chain_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (cs_fall) begin
          state_nxt = src_w ? ST_SRC : ST_SPI;
        end
      end
      ST_SPI: begin
        if (cs_rise) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_SRC: begin
        if (cs_rise) begin
          state_nxt = ST_IDLE;
        end else if (last_w) begin
          state_nxt = ST_END;
        end
      end
      ST_END: begin
        if (cs_rise) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      state_r <= ST_IDLE;
      cfg_r <= PROTO_RST;
      ipr_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      cfg_r <= cfg_w;
      ipr_r <= ipr_w;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      chain_r <= 22'h0;
      sdo_r <= 4'h0;
    end else if (state_idle && cs_fall) begin
      chain_r <= load_w;
      sdo_r <= (!src_w && !cpha_w) ? lanes_out(load_w, nl_w) : 4'h0;
    end else if (cap_w) begin
      chain_r <= shl(chain_r, nl_w, chain_w & sdi_w);
    end else if (launch_spi_w) begin
      sdo_r <= lanes_out(chain_r, nl_w);
    end else if (launch_src_w) begin
      sdo_r <= lanes_out(chain_r, nl_w);
      chain_r <= shl(chain_r, nl_w, 1'b0);
    end
  end

  // strobe stays low outside source-synchronous frames
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      rvs_r <= 1'b0;
      clocks_r <= 4'h0;
      div_cnt_r <= 8'h00;
    end else if (!st_src) begin
      rvs_r <= 1'b0;
      clocks_r <= state_idle ? 4'h0 : clocks_r;
      div_cnt_r <= 8'h00;
    end else begin
      div_cnt_r <= div_en_w ? 8'h00 : div_cnt_r + 8'h01;
      if (tick_w) begin
        rvs_r <= ~rvs_r;
        clocks_r <= rvs_r ? clocks_r + 4'h1 : clocks_r;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      sample_r <= 1'b0;
      chain_valid_r <= 1'b0;
      chain_word_r <= 22'h0;
    end else begin
      sample_r <= trig_rise;
      chain_valid_r <= st_spi & cs_rise;
      if (st_spi && cs_rise) begin
        chain_word_r <= chain_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // drivers only while this device's chip select is low, so a star bus
  // never sees two devices driving at once
  wire [3:0] lane_mask_w = (nl_w == 3'h4) ? 4'hF : (nl_w == 3'h2) ? 4'h3 : 4'h1;
  assign SDO_OE_O = state_idle ? 4'h0 : lane_mask_w;
  assign SDO_O = sdo_r;
  assign READY_STROBE_OUT_O = rvs_r;
  assign SAMPLE_O = sample_r;
  assign CHAIN_VALID_O = chain_valid_r;
  assign CHAIN_WORD_O = chain_word_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  property p_sdr_launch;
    $past(st_src) && st_src && !ddr_w && $changed(sdo_r) |-> $rose(rvs_r);
  endproperty
  a_sdr_launch: assert property (p_sdr_launch) else $error("sdr data moved off rise");

  property p_ddr_fall;
    st_src && ddr_w && tick_w && rvs_r |-> launch_src_w ##1 !rvs_r;
  endproperty
  a_ddr_fall: assert property (p_ddr_fall) else $error("ddr missed falling launch");

  property p_frame_len;
    $rose(state_r == ST_END) |-> clocks_r == frame_w && !rvs_r;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("wrong output clock count");

  property p_strobe_low;
    !st_src |=> !rvs_r;
  endproperty
  a_strobe_low: assert property (p_strobe_low) else $error("strobe high outside frame");

  property p_echo;
    st_src && clksel_w == CLK_EXT && !(sclk_rise || sclk_fall) && !cs_rise |=>
      $stable(rvs_r);
  endproperty
  a_echo: assert property (p_echo) else $error("echo strobe moved without sclk");

  property p_sample;
    trig_rise |=> SAMPLE_O ##1 !SAMPLE_O;
  endproperty
  a_sample: assert property (p_sample) else $error("sample pulse wrong");

  property p_msb_out;
    launch_spi_w && nl_w == 3'h1 |=> sdo_r[0] == $past(chain_r[21]);
  endproperty
  a_msb_out: assert property (p_msb_out) else $error("lane 0 not chain msb");

  property p_shift_in;
    cap_w && chain_w |=> chain_r[0] == $past(sdi_w) && chain_r[21:1] == $past(chain_r[20:0]);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("chain capture wrong");

  property p_decode;
    st_spi && cs_rise |=> CHAIN_VALID_O && CHAIN_WORD_O == $past(chain_r);
  endproperty
  a_decode: assert property (p_decode) else $error("chain not decoded");

  property p_quad;
    launch_src_w && nl_w == 3'h4 |=> sdo_r == {$past(chain_r[18]), $past(chain_r[19]),
                                              $past(chain_r[20]), $past(chain_r[21])};
  endproperty
  a_quad: assert property (p_quad) else $error("quad lane order wrong");

  c_ddr_frame: cover property (st_src && ddr_w ##1 state_r == ST_END);
  c_chain_decode: cover property (chain_w && st_spi && cs_rise);
  c_buf_full: cover property (!RESULT_READY_O);

endmodule : adcsp_port

// [verification/adcsp_host.sv]
`timescale 1ns/100ps
module adcsp_host (
  // clock
  input wire logic clk_i,
  // pins towards the port
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  output logic trig_o,
  input wire logic strobe_i,
  input wire logic [3:0] sdo_i,
  input wire logic [3:0] oe_i
);
  logic prev_r = 1'b0;
  logic ddr_r = 1'b0;
  int lanes_r = 1;
  int rises = 0;
  logic [31:0] cap = '0;
  logic [3:0] oe_seen = '0;

  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    trig_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------
  // mid-cycle sampling keeps clear of the port's own update edge
  always @(negedge clk_i) begin
    prev_r <= strobe_i;
    if (strobe_i === 1'b1 && prev_r === 1'b0) begin
      rises++;
      oe_seen = oe_i;
    end
    if (strobe_i !== prev_r && (strobe_i || ddr_r)) begin
      for (int k = 0; k < lanes_r; k++) cap = {cap[30:0], sdo_i[k]};
    end
  end

  // ----------------------------------------------------------------
  // frames
  // ----------------------------------------------------------------
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hold

  // single device: only this select is ever low
  task automatic src_frame(input logic ddr, input int lanes);
    cap = '0;
    rises = 0;
    ddr_r = ddr;
    lanes_r = lanes;
    cs_n_o <= 1'b0;
    // surplus edges after the frame must be ignored
    repeat (24) begin
      hold(5);
      sclk_o <= ~sclk_o;
    end
    hold(10);
    cs_n_o <= 1'b1;
    hold(8);
  endtask : src_frame

  task automatic spi_frame(input int n, input logic [63:0] sdi, input logic cpha,
                           output logic [63:0] rd);
    rd = '0;
    cs_n_o <= 1'b0;
    // phase one launches on the rise, so the select must be seen first
    hold(7);
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o <= sdi[i];
      if (cpha) sclk_o <= 1'b1;
      hold(7);
      rd = {rd[62:0], sdo_i[0]};
      sclk_o <= ~cpha;
      hold(7);
      if (!cpha) sclk_o <= 1'b0;
    end
    hold(7);
    cs_n_o <= 1'b1;
    hold(8);
  endtask : spi_frame

  task automatic trigger();
    trig_o <= 1'b1;
    hold(6);
    trig_o <= 1'b0;
    hold(6);
  endtask : trigger
endmodule : adcsp_host

// [verification/tb.sv]
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sclk, cs_n, sdi, trig, strobe, samp, rdy, chv;
  logic [3:0] sdo, oe;
  logic [7:0] proto = 8'h00;
  logic [1:0] inproto = 2'h0;
  logic rv = 1'b0;
  logic [21:0] rdata = 22'h0;
  logic [21:0] chw;
  logic [21:0] chain_q[$];
  int miscompares = 0;
  int checked = 0;
  int samples = 0;
  int seed = 32'h4D74;

  always #20 clk = ~clk;

  adcsp_port #(.OSC_HALF(1)) uut (
    .CLK_I(clk), .NRST_I(nrst), .SCLK_I(sclk), .CS_N_I(cs_n), .SDI_I(sdi),
    .CONV_TRIG_I(trig), .READY_STROBE_OUT_O(strobe), .SDO_O(sdo), .SDO_OE_O(oe),
    .OUTPUT_PROTOCOL_REGISTER_I(proto), .INPUT_PROTOCOL_REGISTER_I(inproto),
    .SAMPLE_O(samp), .RESULT_VALID_I(rv), .RESULT_DATA_I(rdata), .RESULT_READY_O(rdy),
    .CHAIN_VALID_O(chv), .CHAIN_WORD_O(chw)
  );

  adcsp_host host (
    .clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .trig_o(trig),
    .strobe_i(strobe), .sdo_i(sdo), .oe_i(oe)
  );

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop

  always @(negedge clk) begin
    if (samp === 1'b1) samples++;
    if (chv === 1'b1) begin
      if (chain_q.size() > 0) check("chain word", chw, chain_q.pop_front());
      else check("chain unexpected", 1, 0);
    end
  end

  // ----------------------------------------------------------------
  // converter side
  // ----------------------------------------------------------------
  task automatic push(input logic [21:0] w);
    int n;
    n = 0;
    rv <= 1'b1;
    rdata <= w;
    forever begin
      @(negedge clk);
      if (rdy === 1'b1) break;
      n++;
      if (n > 2000) begin
        check("push wait", 0, 1);
        report_and_stop();
      end
    end
    @(posedge clk);
    rv <= 1'b0;
    @(posedge clk);
  endtask : push

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [21:0] a, b, d, e, w;
    logic [63:0] rd;
    logic [63:0] exp;
    int s0, n, nb, ln, rate, lcode;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check("strobe reset", strobe, 0);
    check("oe reset", oe, 0);
    check("ready reset", rdy, 1);
    @(posedge clk);
    s0 = samples;
    host.trigger();
    check("sample pulses", samples - s0, 1);
    // fill the buffer until it refuses, a third word stalls meanwhile
    a = 22'($random(seed));
    b = 22'($random(seed));
    push(a);
    push(b);
    rv <= 1'b1;
    rdata <= ~a;
    repeat (4) @(negedge clk) check("ready full", rdy, 0);
    @(posedge clk);
    rv <= 1'b0;
    @(posedge clk);
    // legacy frames drain in order, second one runs twice the length
    d = 22'($random(seed));
    e = 22'($random(seed));
    chain_q.push_back(d);
    host.spi_frame(22, {42'h0, d}, 1'b0, rd);
    check("lane0 read", rd[21:0], a);
    w = 22'($random(seed));
    chain_q.push_back(w);
    host.spi_frame(44, {20'h0, e, w}, 1'b0, rd);
    check("daisy read", rd[43:0], {b, e});
    // phase one: launch on the rise, capture on the fall
    w = 22'($random(seed));
    push(w);
    inproto <= 2'h1;
    d = 22'($random(seed));
    chain_q.push_back(d);
    host.spi_frame(22, {42'h0, d}, 1'b1, rd);
    check("cpha1 read", rd[21:0], w);
    // every clock source, lane count and rate
    for (int c = 0; c < 24; c++) begin
      ln = (c % 3 == 0) ? 1 : (c % 3 == 1) ? 2 : 4;
      lcode = (c % 3 == 0) ? 0 : (c % 3 == 1) ? 2 : 3;
      rate = (c / 3) % 2;
      n = (ln == 1) ? 10 : (ln == 2) ? (rate ? 5 : 10) : (rate ? 3 : 5);
      nb = n * ln * (rate + 1);
      w = 22'($random(seed));
      push(w);
      proto <= 8'((c / 6) * 64 + rate * 16 + lcode * 4 + 3);
      inproto <= 2'($random(seed));
      host.src_frame(rate[0], ln);
      exp = {w, 42'h0} >> (64 - nb);
      check("src clocks", host.rises, n);
      check("src bits", host.cap, exp);
      check("src lanes", host.oe_seen, (ln == 1) ? 1 : (ln == 2) ? 3 : 15);
    end
    check("chain queue", chain_q.size(), 0);
    report_and_stop();
  end
endmodule : tb
